// [shared/evtl_regs.vh]
// constants for the exception vector table lookup block
`ifndef EVTL_REGS_VH
`define EVTL_REGS_VH
`define EVTL_BASE_RESET      32'h00000000
`define EVTL_BASE_MIN        32'h00000100
`define EVTL_BASE_MAX        32'h3FFFFF00
`define EVTL_BASE_ALIGN_MASK 32'hFFFFFF00
`define EVTL_EXC_SP          6'h00
`define EVTL_EXC_RESET       6'h01
`define EVTL_EXC_NMI         6'h02
`define EVTL_EXC_HARD        6'h03
`define EVTL_EXC_MEM         6'h04
`define EVTL_EXC_BUS         6'h05
`define EVTL_EXC_USAGE       6'h06
`define EVTL_EXC_SVC         6'h0B
`define EVTL_EXC_DEBUG       6'h0C
`define EVTL_EXC_PENDABLE_SERVICE_REQUEST      6'h0E
`define EVTL_EXC_SYSTICK     6'h0F
`define EVTL_IRQ_BASE        6'h10
`define EVTL_IRQ_LAST        5'h1D
`define EVTL_IRQ_RSVD_A      5'h09
`define EVTL_IRQ_RSVD_B      5'h0D
`define EVTL_PRIO_RESET      3'h0
`define EVTL_NUM_IRQ         30
`define EVTL_NUM_SYSPRI      16
`define EVTL_CLASS_NONE      2'h0
`define EVTL_CLASS_FAULT     2'h1
`define EVTL_CLASS_SYSTEM    2'h2
`define EVTL_CLASS_ISR       2'h3
`endif

// [verilog/evtl_prio_store.v]
// priority storage: one 3-bit entry per exception number 0..47, registered read
`timescale 1ns/1ps
`include "evtl_regs.vh"
module evtl_prio_store (
	input  wire       clock,
	input  wire       sys_rst,
	input  wire       wr_en,
	input  wire [5:0] wr_num,
	input  wire [2:0] wr_prio,
	input  wire [5:0] rd_num,
	output reg  [2:0] rd_prio
);
	localparam DEPTH = 48;
	reg [2:0] mem [0:DEPTH-1];
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
			localparam [5:0] ENT_NUM = g;
			always @(posedge clock) begin
				if (sys_rst)
					mem[g] <= `EVTL_PRIO_RESET;
				else if (wr_en && wr_num == ENT_NUM)
					mem[g] <= wr_prio;
			end
		end
	endgenerate
	always @(posedge clock) begin
		if (sys_rst)
			rd_prio <= `EVTL_PRIO_RESET;
		else if (rd_num < DEPTH)
			rd_prio <= mem[rd_num];
		else
			rd_prio <= `EVTL_PRIO_RESET;
	end
endmodule

// [verilog/evtl_vector_lookup.v]
// exception vector address generation, table relocation and priority lookup
//
// Contract
// - table word zero is initial stack pointer
// - vector address is base plus four times number
// - programmable priorities reset to zero
// - interrupt n is exception n+16; 9,13 reserved
// - table base is zero after reset
// - privileged relocation within range, used afterwards
// - classify fault, system and interrupt exceptions
// - after reset fetch stack pointer, then reset vector
`timescale 1ns/1ps
`include "evtl_regs.vh"
module evtl_vector_lookup (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        vector_base_relocation_wr,
	input  wire        vector_base_relocation_priv,
	input  wire [31:0] vector_base_relocation_wdata,
	output reg  [31:0] vector_base_relocation,
	output reg         reloc_rejected,
	input  wire        prio_wr,
	input  wire [5:0]  prio_wr_num,
	input  wire [2:0]  prio_wr_value,
	input  wire        lookup_req,
	input  wire [5:0]  lookup_exc_num,
	output wire        lookup_ack,
	output reg  [31:0] vector_addr,
	output reg         vector_valid,
	output reg         vector_is_sp,
	output reg  [1:0]  exc_class,
	output reg  [4:0]  peripheral_interrupt_line,
	output reg         is_peripheral,
	output reg         prio_fixed,
	output wire [2:0]  exc_prio,
	output reg         boot_req,
	output reg  [31:0] boot_addr,
	output reg         boot_sp_phase,
	output reg         boot_done,
	input  wire        boot_ack
);
	localparam BOOT_SP   = 2'h0;
	localparam BOOT_PC   = 2'h1;
	localparam BOOT_DONE = 2'h2;

	reg  [1:0]  boot_state;
	reg  [1:0]  next_boot_state;
	reg  [31:0] masked_base;
	reg         num_valid;
	reg  [1:0]  num_class;
	reg         num_fixed;
	wire [4:0]  irq_idx;
	wire [5:0]  irq_off;
	wire        prio_we;

	// relocation is dropped unless privileged and in range; alignment forced
	always @* begin
		masked_base = vector_base_relocation_wdata & `EVTL_BASE_ALIGN_MASK;
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			vector_base_relocation <= `EVTL_BASE_RESET;
			reloc_rejected         <= 1'b0;
		end else if (vector_base_relocation_wr) begin
			if (vector_base_relocation_priv && masked_base >= `EVTL_BASE_MIN &&
			    masked_base <= `EVTL_BASE_MAX) begin
				vector_base_relocation <= masked_base;
				reloc_rejected         <= 1'b0;
			end else begin
				reloc_rejected <= 1'b1;
			end
		end
	end

	// full-width offset so numbers 48..63 do not wrap onto low interrupts
	assign irq_off = lookup_exc_num - `EVTL_IRQ_BASE;
	assign irq_idx = irq_off[4:0];

	// decode which numbers carry a vector and what handler class they use
	always @* begin
		num_valid = 1'b0;
		num_class = `EVTL_CLASS_NONE;
		num_fixed = 1'b0;
		case (lookup_exc_num)
			`EVTL_EXC_SP: begin
				num_valid = 1'b1;
			end
			`EVTL_EXC_RESET: begin
				num_valid = 1'b1;
				num_fixed = 1'b1;
			end
			`EVTL_EXC_NMI: begin
				num_valid = 1'b1;
				num_class = `EVTL_CLASS_SYSTEM;
				num_fixed = 1'b1;
			end
			`EVTL_EXC_HARD: begin
				num_valid = 1'b1;
				num_class = `EVTL_CLASS_FAULT;
				num_fixed = 1'b1;
			end
			`EVTL_EXC_MEM, `EVTL_EXC_BUS, `EVTL_EXC_USAGE: begin
				num_valid = 1'b1;
				num_class = `EVTL_CLASS_FAULT;
			end
			`EVTL_EXC_SVC, `EVTL_EXC_PENDABLE_SERVICE_REQUEST, `EVTL_EXC_SYSTICK: begin
				num_valid = 1'b1;
				num_class = `EVTL_CLASS_SYSTEM;
			end
			`EVTL_EXC_DEBUG: begin
				num_valid = 1'b1;
			end
			default: begin
				// peripheral range; the two holes have no vector
				if (lookup_exc_num >= `EVTL_IRQ_BASE && irq_off <= {1'b0, `EVTL_IRQ_LAST} &&
				    irq_idx != `EVTL_IRQ_RSVD_A && irq_idx != `EVTL_IRQ_RSVD_B) begin
					num_valid = 1'b1;
					num_class = `EVTL_CLASS_ISR;
				end
			end
		endcase
	end

	assign lookup_ack = lookup_req;

	always @(posedge clock) begin
		if (sys_rst) begin
			vector_addr               <= `EVTL_BASE_RESET;
			vector_valid              <= 1'b0;
			vector_is_sp              <= 1'b0;
			exc_class                 <= `EVTL_CLASS_NONE;
			peripheral_interrupt_line <= 5'h00;
			is_peripheral             <= 1'b0;
			prio_fixed                <= 1'b0;
		end else if (lookup_req) begin
			vector_addr               <= vector_base_relocation + {24'h000000, lookup_exc_num, 2'h0};
			vector_valid              <= num_valid;
			vector_is_sp              <= (lookup_exc_num == `EVTL_EXC_SP);
			exc_class                 <= num_class;
			is_peripheral             <= (num_class == `EVTL_CLASS_ISR);
			peripheral_interrupt_line <= (num_class == `EVTL_CLASS_ISR) ? irq_idx : 5'h00;
			prio_fixed                <= num_fixed;
		end
	end

	// numbers 0..3 and 46..47 keep their store entry at zero; 4..45 are writable, reserved numbers included
	assign prio_we = prio_wr && prio_wr_num > `EVTL_EXC_HARD &&
	                 (prio_wr_num < `EVTL_IRQ_BASE || prio_wr_num <= 6'h2D);

	evtl_prio_store u_prio (
		.clock   (clock),
		.sys_rst (sys_rst),
		.wr_en   (prio_we),
		.wr_num  (prio_wr_num),
		.wr_prio (prio_wr_value),
		.rd_num  (lookup_exc_num),
		.rd_prio (exc_prio)
	);

	// boot sequence: stack pointer word, then reset handler word
	always @* begin
		next_boot_state = boot_state;
		case (boot_state)
			BOOT_SP:   if (boot_ack) next_boot_state = BOOT_PC;
			BOOT_PC:   if (boot_ack) next_boot_state = BOOT_DONE;
			BOOT_DONE: next_boot_state = BOOT_DONE;
			default:   next_boot_state = BOOT_SP;
		endcase
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			boot_state    <= BOOT_SP;
			boot_req      <= 1'b0;
			boot_addr     <= `EVTL_BASE_RESET;
			boot_sp_phase <= 1'b0;
			boot_done     <= 1'b0;
		end else begin
			boot_state    <= next_boot_state;
			boot_req      <= (next_boot_state != BOOT_DONE);
			boot_sp_phase <= (next_boot_state == BOOT_SP);
			boot_done     <= (next_boot_state == BOOT_DONE);
			// boot always uses the reset-time base of zero
			boot_addr     <= (next_boot_state == BOOT_PC) ? {24'h000000, `EVTL_EXC_RESET, 2'h0} :
			                 `EVTL_BASE_RESET;
		end
	end
endmodule

// [dv/evtl_props.sv]
// port assertions for the vector lookup block
`timescale 1ns/1ps
module evtl_props (
	input wire        clock,
	input wire        sys_rst,
	input wire        vector_base_relocation_wr,
	input wire        vector_base_relocation_priv,
	input wire [31:0] vector_base_relocation_wdata,
	input wire [31:0] vector_base_relocation,
	input wire        lookup_req,
	input wire [5:0]  lookup_exc_num,
	input wire [31:0] vector_addr,
	input wire        vector_is_sp,
	input wire [1:0]  exc_class,
	input wire [31:0] boot_addr,
	input wire        boot_sp_phase,
	input wire        boot_ack
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	wire [5:0]  n = lookup_exc_num;
	wire [31:0] m = vector_base_relocation_wdata & 32'hFFFFFF00;
	wire        ok = vector_base_relocation_priv && m >= 32'h00000100 && m <= 32'h3FFFFF00;
	sp_entry_a: assert property (lookup_req |=> vector_is_sp == ($past(n) == 6'h00)) else $error("sp flag");
	addr_calc_a: assert property (lookup_req && n < 6'h07 |=>
		vector_addr == $past(vector_base_relocation) + {$past(n), 2'b00}) else $error("vector address");
	fault_cls_a: assert property (lookup_req && n >= 6'h03 && n <= 6'h06 |=> exc_class == 2'h1) else $error("class");
	reset_base_a: assert property ($fell(sys_rst) |-> vector_base_relocation == 32'h0) else $error("base");
	boot_start_a: assert property ($fell(sys_rst) |=> boot_sp_phase && boot_addr == 32'h0) else $error("boot");
	boot_step_a: assert property (boot_sp_phase && boot_ack |=> !boot_sp_phase && boot_addr == 32'h4) else $error("step");
	reloc_take_a: assert property (vector_base_relocation_wr && ok |=> vector_base_relocation == $past(m)) else $error("take");
	reloc_keep_a: assert property (vector_base_relocation_wr && !ok |=> $stable(vector_base_relocation)) else $error("keep");
	cover property (boot_ack && !boot_sp_phase);
	cover property (lookup_req && n == 6'h2D);
	cover property (vector_base_relocation_wr && !ok);
endmodule
bind evtl_vector_lookup evtl_props evtl_props_inst (.*);

// [dv/evtl_core_model.sv]
// core boot fetch responder with adjustable latency
`timescale 1ns/1ps
module evtl_core_model (
	input wire       clock,
	input wire       sys_rst,
	input wire       boot_req,
	input wire [1:0] boot_delay,
	output reg       boot_ack
);
	reg [1:0] cnt;
	// count restarts after each ack so the second fetch waits as long as the first
	always @(posedge clock) begin
		boot_ack <= !sys_rst && boot_req && !boot_ack && cnt == boot_delay;
		cnt <= (sys_rst || !boot_req || boot_ack) ? 2'h0 : cnt + 2'h1;
	end
endmodule

// [dv/testbench.sv]
// self-checking bench for the vector lookup block
`timescale 1ns/1ps
module testbench;
	logic        clock = 0, sys_rst = 1, lookup_req = 0, prio_wr = 0, ok;
	logic        vector_base_relocation_wr = 0, vector_base_relocation_priv = 0;
	logic [31:0] vector_base_relocation_wdata = 0, vector_base_relocation, vector_addr, boot_addr, base;
	logic [5:0]  lookup_exc_num = 0, prio_wr_num = 0;
	logic [4:0]  peripheral_interrupt_line;
	logic [2:0]  prio_wr_value = 0, exc_prio;
	logic [1:0]  exc_class, boot_delay = 0;
	logic        reloc_rejected, lookup_ack, vector_valid, vector_is_sp, is_peripheral, prio_fixed;
	logic        boot_req, boot_sp_phase, boot_done, boot_ack;
	int          mismatches = 0, total_checks = 0;
	evtl_vector_lookup evtl_vector_lookup_inst (.*);
	evtl_core_model evtl_core_model_inst (.*);
	initial forever #10 clock = ~clock;
	function logic ev(input [5:0] n);
		return n <= 6'h2D && !(n inside {7, 8, 9, 10, 13, 25, 29});
	endfunction
	task chk(input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task rst(input [1:0] d);
		sys_rst <= 1;
		boot_delay <= d;
		repeat (5) @(posedge clock);
		sys_rst <= 0;
		base = 0;
		for (int i = 0; i < 20 && boot_done !== 1; i++) begin
			@(posedge clock);
			#1;
		end
		chk(boot_done, 1);
		chk({boot_req, boot_sp_phase}, 0);
		chk(vector_base_relocation, 0);
	endtask
	task pw(input [5:0] n, input [2:0] v);
		@(posedge clock);
		prio_wr <= 1;
		prio_wr_num <= n;
		prio_wr_value <= v;
		@(posedge clock);
		prio_wr <= 0;
	endtask
	task lk(input [5:0] n, input logic p0);
		@(posedge clock);
		lookup_req <= 1;
		lookup_exc_num <= n;
		#1 chk(lookup_ack, 1);
		@(posedge clock);
		lookup_req <= 0;
		#1 chk(vector_valid, ev(n));
		chk(lookup_ack, 0);
		chk({is_peripheral, prio_fixed}, {n >= 16 && ev(n), n inside {1, 2, 3}});
		if (!(n >= 16 && ev(n))) chk(peripheral_interrupt_line, 0);
		chk(vector_is_sp, n == 0);
		if (ev(n)) chk(vector_addr, base + 4 * n);
		if (n >= 3 && n <= 6) chk(exc_class, 1);
		if (n inside {2, 11, 14, 15}) chk(exc_class, 2);
		if (n >= 16 && ev(n)) chk({exc_class, peripheral_interrupt_line}, {2'h3, 5'(n - 16)});
		if (p0) chk(exc_prio, 0);
	endtask
	task wr(input [31:0] d, input logic p);
		@(posedge clock);
		vector_base_relocation_wr <= 1;
		vector_base_relocation_priv <= p;
		vector_base_relocation_wdata <= d;
		@(posedge clock);
		vector_base_relocation_wr <= 0;
		d = d & 32'hFFFFFF00;
		ok = p && d >= 32'h100 && d <= 32'h3FFFFF00;
		if (ok) base = d;
		#1 chk(vector_base_relocation, base);
		chk(reloc_rejected, !ok);
	endtask
	initial begin
		#100000 mismatches++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'h148A));
		rst(0);
		for (int k = 0; k < 64; k++) lk(6'(k), 1);
		pw(15, 5);
		lk(15, 0);
		chk(exc_prio, 5);
		pw(3, 7);
		lk(3, 1);
		pw(6'h2D, 4);
		lk(6'h2D, 0);
		chk(exc_prio, 4);
		wr(32'h100, 1);
		wr(32'h3FFFFFFF, 1);
		wr(32'hFF, 1);
		wr(32'h40000000, 1);
		wr(32'h2000, 0);
		for (int k = 0; k < 40; k++) begin
			if (k % 8 == 0) wr((32'h100 + $urandom % 32'h3FFFFE00) & 32'hFFFFFF00, 1);
			lk(6'($urandom % 48), 0);
		end
		rst(3);
		lk(6'h2D, 0);
		tally_and_finish;
	end
endmodule
